// *** pkg/fqt_regs.vh ***
`ifndef FQT_REGS_VH
`define FQT_REGS_VH
// Register byte offsets on the bus
`define FQT_REG_CMD 12'h000
`define FQT_REG_MODE 12'h004
`define FQT_REG_QSEL 12'h008
`define FQT_REG_QDATA 12'h00C
`define FQT_REG_QCNT 12'h010
// Read window: adr[11:10] selects it, adr[9:2] is the word offset
`define FQT_WIN_HI 11
`define FQT_WIN_LO 10
`define FQT_WIN_SEL 2'h1
`define FQT_WIDX_HI 9
`define FQT_WIDX_LO 2
// Mode register fields
`define FQT_MODE_QUERY 0
`define FQT_MODE_BADCMD 1
`define FQT_MODE_TMO 2
// Commands written to the command register
`define FQT_CMD_QUERY 8'h98
`define FQT_CMD_ARRAY 8'hFF
`define FQT_CMD_ARRAY_ALT 8'hF0
// Query offsets
`define FQT_Q_VEND_LO 8'h01
`define FQT_Q_VEND_HI 8'h0F
`define FQT_Q_SIG0 8'h10
`define FQT_Q_SIG1 8'h11
`define FQT_Q_SIG2 8'h12
`define FQT_Q_PID_LO 8'h13
`define FQT_Q_PID_HI 8'h14
`define FQT_Q_PTR_LO 8'h15
`define FQT_Q_PTR_HI 8'h16
`define FQT_Q_AID_LO 8'h17
`define FQT_Q_AID_HI 8'h18
`define FQT_Q_SEC_LO 8'h19
`define FQT_Q_SEC_HI 8'h1A
`define FQT_Q_VCC_MIN 8'h1B
`define FQT_Q_VCC_MAX 8'h1C
`define FQT_Q_VPP_MIN 8'h1D
`define FQT_Q_VPP_MAX 8'h1E
`define FQT_Q_T_WORD 8'h1F
`define FQT_Q_T_BUF 8'h20
`define FQT_Q_T_BLK 8'h21
`define FQT_Q_T_CHIP 8'h22
`define FQT_Q_M_WORD 8'h23
`define FQT_Q_M_BUF 8'h24
`define FQT_Q_M_BLK 8'h25
`define FQT_Q_M_CHIP 8'h26
// Query contents
`define FQT_D_NONE 8'h00
`define FQT_D_SIG0 8'h51
`define FQT_D_SIG1 8'h52
`define FQT_D_SIG2 8'h59
`define FQT_D_PTR_LO 8'h0A
`define FQT_D_PTR_HI 8'h01
`define FQT_D_VCC_MIN 8'h17
`define FQT_D_VCC_MAX 8'h20
`define FQT_D_VPP_MIN 8'h85
`define FQT_D_VPP_MAX 8'h95
`define FQT_D_T_WORD 8'h08
`define FQT_D_T_BUF 8'h09
`define FQT_D_T_BLK 8'h0A
`define FQT_D_M_WORD 8'h01
`define FQT_D_M_BUF 8'h01
`define FQT_D_M_BLK 8'h02
// Reset values and counts
`define FQT_RST_BYTE 8'h00
`define FQT_RST_WORD 16'h0000
`define FQT_ZERO32 32'h00000000
`define FQT_ARRAY_TMO 8'h40
`endif

// *** verilog/fqt_rom.v ***
`timescale 1ns/100ps
`include "fqt_regs.vh"
module fqt_rom #(
	parameter [7:0] VENDOR_FILL = 8'hA5, // Arbitrary value for vendor-reserved offsets
	parameter [15:0] CMDSET_ID = 16'h5A3C // Arbitrary primary command set code
) (
	input wire [7:0] offset, // Query word offset
	output reg [15:0] data // Query word
);
reg [7:0] lo;

always @* begin
	lo = `FQT_D_NONE;
	if (offset >= `FQT_Q_VEND_LO && offset <= `FQT_Q_VEND_HI) begin
		lo = VENDOR_FILL;
	end else begin
		case (offset)
		`FQT_Q_SIG0: lo = `FQT_D_SIG0;
		`FQT_Q_SIG1: lo = `FQT_D_SIG1;
		`FQT_Q_SIG2: lo = `FQT_D_SIG2;
		`FQT_Q_PID_LO: lo = CMDSET_ID[7:0];
		`FQT_Q_PID_HI: lo = CMDSET_ID[15:8];
		`FQT_Q_PTR_LO: lo = `FQT_D_PTR_LO;
		`FQT_Q_PTR_HI: lo = `FQT_D_PTR_HI;
		`FQT_Q_AID_LO: lo = `FQT_D_NONE;
		`FQT_Q_AID_HI: lo = `FQT_D_NONE;
		`FQT_Q_SEC_LO: lo = `FQT_D_NONE;
		`FQT_Q_SEC_HI: lo = `FQT_D_NONE;
		`FQT_Q_VCC_MIN: lo = `FQT_D_VCC_MIN;
		`FQT_Q_VCC_MAX: lo = `FQT_D_VCC_MAX;
		`FQT_Q_VPP_MIN: lo = `FQT_D_VPP_MIN;
		`FQT_Q_VPP_MAX: lo = `FQT_D_VPP_MAX;
		`FQT_Q_T_WORD: lo = `FQT_D_T_WORD;
		`FQT_Q_T_BUF: lo = `FQT_D_T_BUF;
		`FQT_Q_T_BLK: lo = `FQT_D_T_BLK;
		`FQT_Q_T_CHIP: lo = `FQT_D_NONE;
		`FQT_Q_M_WORD: lo = `FQT_D_M_WORD;
		`FQT_Q_M_BUF: lo = `FQT_D_M_BUF;
		`FQT_Q_M_BLK: lo = `FQT_D_M_BLK;
		`FQT_Q_M_CHIP: lo = `FQT_D_NONE;
		default: lo = `FQT_D_NONE;
		endcase
	end
	data = {`FQT_D_NONE, lo};
end
endmodule

// *** verilog/fqt_mode.v ***
`timescale 1ns/100ps
`include "fqt_regs.vh"
module fqt_mode (
	input wire ref_clk, // System clock
	input wire rst, // Asynchronous reset, active high
	input wire cmd_wr, // Command byte write strobe
	input wire [7:0] cmd_data, // Command byte
	input wire clr_bad, // Clear unknown-command flag
	output reg query_mode, // Query output mode active
	output reg [7:0] last_cmd, // Last command byte written
	output reg bad_cmd // Sticky unknown-command flag
);
wire is_query;
wire is_array;

assign is_query = cmd_data == `FQT_CMD_QUERY;
assign is_array = cmd_data == `FQT_CMD_ARRAY || cmd_data == `FQT_CMD_ARRAY_ALT;

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		query_mode <= 1'b0;
		last_cmd <= `FQT_RST_BYTE;
		bad_cmd <= 1'b0;
	end else begin
		if (cmd_wr) begin
			last_cmd <= cmd_data;
		end
		// Query mode holds until an array read command arrives
		if (cmd_wr && is_query) begin
			query_mode <= 1'b1;
		end else if (cmd_wr && is_array) begin
			query_mode <= 1'b0;
		end
		// Unknown commands leave the mode alone; setting wins over clearing
		if (cmd_wr && !is_query && !is_array) begin
			bad_cmd <= 1'b1;
		end else if (clr_bad) begin
			bad_cmd <= 1'b0;
		end
	end
end
endmodule

// *** verilog/fqt_query.v ***
// Summary of operation
// - Query command switches reads to query table
// - Offsets 1 to Fh hold vendor filler
// - Offsets 10h-12h return 51, 52, 59
// - Offsets 13h/14h hold primary command-set code
// - Offsets 15h/16h hold pointer 010Ah
// - Offsets 17h/18h return zero, no alternate
// - Offsets 19h/1Ah return zero, no secondary table
// - Offsets 1Bh/1Ch return 17 and 20
// - Offsets 1Dh/1Eh return 85 and 95
// - Offset 1Fh returns word program exponent 08
// - Offset 20h returns buffer program exponent 09
// - Offset 21h returns block erase exponent 0A
// - Offsets 22h and 26h return 00
// - Offset 23h returns 01
// - Offset 24h returns 01
// - Offset 25h returns 02
// - Upper byte of every query word is zero
// - Multi-byte fields are stored low byte first
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "fqt_regs.vh"
module fqt_query #(
	parameter [7:0] ARRAY_TMO = `FQT_ARRAY_TMO, // Cycles to wait for array data
	parameter [7:0] VENDOR_FILL = 8'hA5, // Arbitrary value for vendor-reserved offsets
	parameter [15:0] CMDSET_ID = 16'h5A3C // Arbitrary primary command set code
) (
	input wire ref_clk, // System clock, 25 MHz
	input wire rst, // Asynchronous reset, active high
	input wire wb_cyc_i, // Bus cycle
	input wire wb_stb_i, // Strobe
	input wire wb_we_i, // Write enable
	input wire [11:0] wb_adr_i, // Byte address
	input wire [3:0] wb_sel_i, // Byte lane selects
	input wire [31:0] wb_dat_i, // Write data
	output reg [31:0] wb_dat_o, // Read data
	output reg wb_ack_o, // Acknowledge
	output reg array_req, // Array read request, held until valid or the timeout
	output reg [7:0] array_addr, // Array word address
	input wire [15:0] array_data, // Array read data
	input wire array_valid, // Array data valid
	output reg query_active // Query output mode flag
);
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_ARRAY = 2'b01;
localparam [1:0] ST_DONE = 2'b10;

reg [1:0] state;
reg [7:0] qsel;
reg [15:0] qcnt;
reg [7:0] tmo_cnt;
reg tmo_err;
reg [31:0] next_dat;
reg [7:0] rom_off;

// One-hot register selects from the address decode
reg sel_cmd;
reg sel_mode;
reg sel_qsel;
reg sel_qdata;
reg sel_qcnt;

// Next values; each register below except query_active is loaded from exactly one of these
reg [1:0] next_state;
reg next_ack;
reg [31:0] next_rdata;
reg next_array_req;
reg [7:0] next_array_addr;
reg [7:0] next_tmo_cnt;
reg [7:0] next_qsel;
reg [15:0] next_qcnt;
reg next_tmo_err;

wire req;
wire win_hit;
wire [7:0] win_idx;
wire query_mode;
wire [7:0] last_cmd;
wire bad_cmd;
wire [15:0] rom_data;
wire cmd_wr;
wire mode_wr;
wire qsel_wr;
wire qcnt_wr;
wire array_rd;
wire query_rd;
wire tmo_hit;

// A new request is only taken while idle, one at a time
assign req = wb_cyc_i && wb_stb_i && state == ST_IDLE;
assign win_hit = wb_adr_i[`FQT_WIN_HI:`FQT_WIN_LO] == `FQT_WIN_SEL;
assign win_idx = wb_adr_i[`FQT_WIDX_HI:`FQT_WIDX_LO];

// Named registers by exact address; window and unmapped addresses select none
always @* begin
	sel_cmd = 1'b0;
	sel_mode = 1'b0;
	sel_qsel = 1'b0;
	sel_qdata = 1'b0;
	sel_qcnt = 1'b0;
	if (wb_adr_i == `FQT_REG_CMD) begin
		sel_cmd = 1'b1;
	end else if (wb_adr_i == `FQT_REG_MODE) begin
		sel_mode = 1'b1;
	end else if (wb_adr_i == `FQT_REG_QSEL) begin
		sel_qsel = 1'b1;
	end else if (wb_adr_i == `FQT_REG_QDATA) begin
		sel_qdata = 1'b1;
	end else if (wb_adr_i == `FQT_REG_QCNT) begin
		sel_qcnt = 1'b1;
	end
end

// Byte-wide registers need lane 0; the counter clears on any write
assign cmd_wr = req && wb_we_i && wb_sel_i[0] && sel_cmd;
assign mode_wr = req && wb_we_i && wb_sel_i[0] && sel_mode;
assign qsel_wr = req && wb_we_i && wb_sel_i[0] && sel_qsel;
assign qcnt_wr = req && wb_we_i && sel_qcnt;

// Window reads go to the array unless query mode is on
assign array_rd = req && !wb_we_i && win_hit && !query_mode;
assign query_rd = req && !wb_we_i && win_hit && query_mode;

// The wait counter starts at zero, so the last waiting cycle is one below the limit
assign tmo_hit = state == ST_ARRAY && !array_valid && tmo_cnt == ARRAY_TMO - 8'h01;

fqt_mode u_mode (
	.ref_clk(ref_clk),
	.rst(rst),
	.cmd_wr(cmd_wr),
	.cmd_data(wb_dat_i[7:0]),
	.clr_bad(mode_wr && wb_dat_i[`FQT_MODE_BADCMD]),
	.query_mode(query_mode),
	.last_cmd(last_cmd),
	.bad_cmd(bad_cmd)
);

fqt_rom #(
	.VENDOR_FILL(VENDOR_FILL),
	.CMDSET_ID(CMDSET_ID)
) u_rom (
	.offset(rom_off),
	.data(rom_data)
);

// The table is shared by the window and the indirect data register
always @* begin
	if (win_hit) begin
		rom_off = win_idx;
	end else begin
		rom_off = qsel;
	end
end

// Read data for requests answered from local state
always @* begin
	next_dat = `FQT_ZERO32;
	if (win_hit) begin
		if (query_mode) begin
			next_dat = {`FQT_RST_WORD, rom_data};
		end
	end else if (sel_cmd) begin
		next_dat = {`FQT_RST_WORD, `FQT_RST_BYTE, last_cmd};
	end else if (sel_mode) begin
		next_dat[`FQT_MODE_QUERY] = query_mode;
		next_dat[`FQT_MODE_BADCMD] = bad_cmd;
		next_dat[`FQT_MODE_TMO] = tmo_err;
	end else if (sel_qsel) begin
		next_dat = {`FQT_RST_WORD, `FQT_RST_BYTE, qsel};
	end else if (sel_qdata) begin
		if (query_mode) begin
			next_dat = {`FQT_RST_WORD, rom_data};
		end
	end else if (sel_qcnt) begin
		next_dat = {`FQT_RST_WORD, qcnt};
	end else begin
		next_dat = `FQT_ZERO32;
	end
end

// Bus sequencer: one request at a time, one-cycle ack, no new request taken during the ack cycle
always @* begin
	next_state = state;
	next_ack = 1'b0;
	case (state)
	ST_IDLE: begin
		// Array-mode window reads wait for the array before acking
		if (array_rd) begin
			next_state = ST_ARRAY;
		end else if (req) begin
			next_ack = 1'b1;
			next_state = ST_DONE;
		end
	end
	ST_ARRAY: begin
		// A word and the timeout never meet: the timeout needs valid low
		if (array_valid || tmo_hit) begin
			next_ack = 1'b1;
			next_state = ST_DONE;
		end
	end
	ST_DONE: begin
		// Ack is high for this one cycle; the master releases as it ends
		next_state = ST_IDLE;
	end
	default: begin
		next_state = ST_IDLE;
	end
	endcase
end

// Array link: request and address hold until a word or the timeout
always @* begin
	next_array_req = array_req;
	next_array_addr = array_addr;
	next_tmo_cnt = tmo_cnt;
	case (state)
	ST_IDLE: begin
		if (array_rd) begin
			next_array_req = 1'b1;
			next_array_addr = win_idx;
			next_tmo_cnt = `FQT_RST_BYTE;
		end
	end
	ST_ARRAY: begin
		if (array_valid || tmo_hit) begin
			next_array_req = 1'b0;
		end else begin
			next_tmo_cnt = tmo_cnt + 8'h01;
		end
	end
	default: begin
		// Done and any stray code: the link is idle or made idle
		next_array_req = 1'b0;
	end
	endcase
end

// Read data holds until the next read answer
always @* begin
	next_rdata = wb_dat_o;
	case (state)
	ST_IDLE: begin
		// Writes leave the last read word in place
		if (req && !array_rd && !wb_we_i) begin
			next_rdata = next_dat;
		end
	end
	ST_ARRAY: begin
		if (array_valid) begin
			next_rdata = {`FQT_RST_WORD, array_data};
		end else if (tmo_hit) begin
			// No answer from the array: finish with zero data
			next_rdata = `FQT_ZERO32;
		end
	end
	default: begin
		next_rdata = wb_dat_o;
	end
	endcase
end

// Bus-side registers
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		state <= ST_IDLE;
		wb_ack_o <= 1'b0;
		wb_dat_o <= `FQT_ZERO32;
		array_req <= 1'b0;
		array_addr <= `FQT_RST_BYTE;
		tmo_cnt <= `FQT_RST_BYTE;
	end else begin
		state <= next_state;
		wb_ack_o <= next_ack;
		wb_dat_o <= next_rdata;
		array_req <= next_array_req;
		array_addr <= next_array_addr;
		tmo_cnt <= next_tmo_cnt;
	end
end

// Indirect offset register and query read counter
always @* begin
	next_qsel = qsel;
	next_qcnt = qcnt;
	if (qsel_wr) begin
		next_qsel = wb_dat_i[7:0];
	end
	// Any write clears the counter; it saturates instead of wrapping
	if (qcnt_wr) begin
		next_qcnt = `FQT_RST_WORD;
	end else if (query_rd && qcnt != ~`FQT_RST_WORD) begin
		next_qcnt = qcnt + 16'h0001;
	end
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		qsel <= `FQT_RST_BYTE;
		qcnt <= `FQT_RST_WORD;
	end else begin
		qsel <= next_qsel;
		qcnt <= next_qcnt;
	end
end

// Sticky timeout flag; a new timeout wins over a clear
always @* begin
	next_tmo_err = tmo_err;
	if (tmo_hit) begin
		next_tmo_err = 1'b1;
	end else if (mode_wr && wb_dat_i[`FQT_MODE_TMO]) begin
		next_tmo_err = 1'b0;
	end
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		tmo_err <= 1'b0;
	end else begin
		tmo_err <= next_tmo_err;
	end
end

// Mode flag brought out from a flip-flop of this module
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		query_active <= 1'b0;
	end else begin
		query_active <= query_mode;
	end
end
endmodule

// *** verif/fqt_array_model.sv ***
`timescale 1ns/100ps
module fqt_array_model #(
	parameter int LAT = 3 // Wait cycles before answering
) (
	input wire ref_clk, // Clock
	input wire rst, // Reset
	input wire stall, // Never answer
	input wire array_req, // Read request
	input wire [7:0] array_addr, // Word address
	output logic [15:0] array_data, // Read word
	output logic array_valid // Word valid
);
	int cnt;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			array_valid <= 1'b0;
			array_data <= 16'h0000;
		end else begin
			array_valid <= 1'b0;
			// Garbage that moves every cycle outside an answer
			array_data <= ~array_data;
			if (!array_req || stall) begin
				cnt <= 0;
			end else if (!array_valid) begin
				cnt <= cnt + 1;
				if (cnt == LAT) begin
					array_valid <= 1'b1;
					array_data <= {array_addr, ~array_addr};
				end
			end
		end
	end
endmodule

// *** verif/fqt_query_sva.sv ***
`timescale 1ns/100ps
module fqt_query_sva #(
	parameter [7:0] ARRAY_TMO = 8'h40 // Array wait limit
) (
	input wire ref_clk, // Clock
	input wire rst, // Reset
	input wire wb_cyc_i, // Cycle
	input wire wb_stb_i, // Strobe
	input wire wb_we_i, // Write
	input wire [11:0] wb_adr_i, // Address
	input wire [3:0] wb_sel_i, // Lanes
	input wire [31:0] wb_dat_i, // Write data
	input wire [31:0] wb_dat_o, // Read data
	input wire wb_ack_o, // Ack
	input wire array_req, // Array request
	input wire [7:0] array_addr, // Array address
	input wire [15:0] array_data, // Array data
	input wire array_valid, // Array valid
	input wire query_active // Query mode
);
	localparam int ACK_MAX = 70;
	localparam [183:0] QTAB =
		184'h00_02_01_01_00_0A_09_08_95_85_20_17_00_00_00_00_01_0A_00_00_59_52_51;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire rd_q = wb_ack_o && query_active && !wb_we_i && wb_adr_i[11:10] == 2'h1;
	wire [7:0] qo = wb_adr_i[9:2];
	wire w_req = wb_cyc_i && wb_stb_i && wb_we_i;
	reg [8:0] req_cnt;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_cnt <= 9'h000;
		end else begin
			req_cnt <= array_req ? req_cnt + 9'h001 : 9'h000;
		end
	end
	sequence s_arr_hit;
		array_req && array_valid;
	endsequence
	sequence s_arr_ans;
		wb_ack_o && wb_dat_o == {16'h0000, $past(array_data)};
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_bound: assert property ($rose(wb_stb_i) |-> ##[1:ACK_MAX] wb_ack_o)
		else $error("no ack");
	a_query_bytes: assert property (rd_q && qo >= 8'h10 && qo <= 8'h26 && qo != 8'h13 &&
		qo != 8'h14 |-> wb_dat_o[7:0] == QTAB[(qo - 8'h10) * 8 +: 8])
		else $error("query byte wrong");
	a_upper_zero: assert property (rd_q |-> wb_dat_o[31:8] == 24'h000000)
		else $error("query upper bits set");
	a_array_answer: assert property (s_arr_hit |=> s_arr_ans)
		else $error("array word not returned");
	a_addr_stable: assert property (array_req && $past(array_req) |-> $stable(array_addr))
		else $error("array address moved");
	a_req_bound: assert property (req_cnt <= ARRAY_TMO + 9'h001)
		else $error("array wait too long");
	a_query_enter: assert property (w_req && wb_adr_i == 12'h000 &&
		wb_dat_i[7:0] == 8'h98 |-> ##[1:3] query_active)
		else $error("query mode not entered");
	a_query_stays: assert property (query_active && !w_req && !$past(w_req) |=> query_active)
		else $error("query mode lost");
endmodule
bind fqt_query fqt_query_sva #(.ARRAY_TMO(ARRAY_TMO)) u_sva (.ref_clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .array_req,
	.array_addr, .array_data, .array_valid, .query_active);

// *** verif/fqt_query_bench.sv ***
`timescale 1ns/100ps
module fqt_query_bench;
	logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, stall = 0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dw = 32'h00000000, rd, dr;
	logic ack, areq, avalid, qact;
	logic [7:0] aaddr;
	logic [15:0] adata;
	integer bad_count = 0, tests_run = 0, i;
	logic [7:0] ptr_lo;
	logic [15:0] rows [23] = '{16'h1051, 16'h1152, 16'h1259, 16'h132D, 16'h146B, 16'h150A,
		16'h1601, 16'h1700, 16'h1800, 16'h1900, 16'h1A00, 16'h1B17, 16'h1C20, 16'h1D85,
		16'h1E95, 16'h1F08, 16'h2009, 16'h210A, 16'h2200, 16'h2301, 16'h2401, 16'h2502, 16'h2600};
	logic [7:0] cmds [2] = '{8'hFF, 8'hF0};
	fqt_query #(.ARRAY_TMO(8'h08), .VENDOR_FILL(8'hC3), .CMDSET_ID(16'h6B2D)) uut (
		.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.array_req(areq), .array_addr(aaddr), .array_data(adata), .array_valid(avalid),
		.query_active(qact));
	fqt_array_model #(.LAT(3)) u_arr (.ref_clk(ref_clk), .rst(rst), .stall(stall),
		.array_req(areq), .array_addr(aaddr), .array_data(adata), .array_valid(avalid));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	task results;
		$display("tests %0d wrong %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 100) begin
			bad_count++;
			results;
		end
	endtask
	task rdq(input logic [7:0] o);
		bus(1'b0, {2'h1, o, 2'h0}, 32'h00000000);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk({31'h0, qact}, 32'h00000000, "reset mode");
		rdq(8'h10);
		chk(rd, 32'h000010EF, "array read");
		bus(1'b1, 12'h000, 32'h00000098);
		for (i = 0; i < 23; i++) begin
			rdq(rows[i][15:8]);
			chk(rd, {24'h000000, rows[i][7:0]}, "query byte");
		end
		rdq(8'h15);
		ptr_lo = rd[7:0];
		rdq(8'h16);
		chk({16'h0000, rd[7:0], ptr_lo}, 32'h0000010A, "table pointer");
		bus(1'b1, 12'h008, 32'h0000001F);
		bus(1'b0, 12'h00C, 32'h00000000);
		chk(rd, 32'h00000008, "indirect read");
		bus(1'b0, 12'h010, 32'h00000000);
		chk(rd, 32'h00000019, "query read count");
		$display("table done");
		rdq(8'h05);
		chk(rd & 32'hFFFFFF00, 32'h00000000, "vendor upper");
		chk(rd, 32'h000000C3, "vendor fill");
		bus(1'b1, 12'h000, 32'h00000055);
		rdq(8'h10);
		chk(rd, 32'h00000051, "unknown command");
		bus(1'b0, 12'h000, 32'h00000000);
		chk(rd, 32'h00000055, "last command");
		bus(1'b0, 12'h004, 32'h00000000);
		chk(rd & 32'h00000003, 32'h00000003, "mode flags");
		$display("bad command done");
		for (i = 0; i < 2; i++) begin
			bus(1'b1, 12'h000, {24'h000000, cmds[i]});
			rdq(8'h11);
			chk(rd, 32'h000011EE, "array again");
			bus(1'b1, 12'h000, 32'h00000098);
		end
		bus(1'b1, 12'h000, 32'h000000FF);
		$display("exit done");
		stall <= 1'b1;
		rdq(8'h20);
		chk(rd, 32'h00000000, "array timeout");
		stall <= 1'b0;
		bus(1'b0, 12'h004, 32'h00000000);
		chk(rd & 32'h00000005, 32'h00000004, "timeout flag");
		bus(1'b1, 12'h004, 32'h00000006);
		bus(1'b0, 12'h004, 32'h00000000);
		chk(rd & 32'h00000007, 32'h00000000, "flags cleared");
		bus(1'b0, 12'h020, 32'h00000000);
		chk(rd, 32'h00000000, "unmapped");
		$display("timeout done");
		results;
	end
endmodule
